// ===== bench/analog_side_model.sv
/*
 * Comparator and clock sources facing the converter control.
 * Assumes the bench sets the input level in steps of 1/2048 of full scale.
 */
module analog_side_model (
    input  wire logic [11:0] level,
    input  wire logic        sampleEnable,
    input  wire logic [10:0] dacCode,
    input  wire logic        asyncOscEnable,
    input  wire logic        asyncOscSlow,
    output logic             compareHigh,
    output logic             asyncOscIn,
    output logic             oscOutClkIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] held = 12'h000;
    // Track the mux output while sampling, hold it through the trials
    always @(sampleEnable or level) if (sampleEnable) held = level;
    // Levels past the top reference compare high against every code
    assign compareHigh = held >= {1'b0, dacCode};
    // Dedicated oscillator runs only on request, stop mode included
    initial begin
        asyncOscIn = 1'b0;
        forever begin
            #(asyncOscSlow ? 666 : 333);
            asyncOscIn = asyncOscEnable ? ~asyncOscIn : 1'b0;
        end
    end
    // Oscillator output clock runs free, unrelated to the bus clock
    initial begin
        oscOutClkIn = 1'b0;
        forever #200 oscOutClkIn = ~oscOutClkIn;
    end
endmodule

// ===== bench/sar_adc_control_checker.sv
/*
 * Port assertions for the converter control block.
 * Assumes it is bound to the control block from the bench top file.
 */
module sar_adc_control_checker #(
    parameter int SAMPLE_TICKS = 4
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        stopMode,
    input wire logic        asyncOscEnable,
    input wire logic        asyncOscSlow,
    input wire logic        converterActive,
    input wire logic        completeIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic wrSc;
    logic wrCc;
    logic asyncBit;
    // Writes as they take effect, at the acking edge
    assign wrSc = ack_o && we_i && sel_i[0] && adr_i == sar_adc_pkg::STATUS_CONTROL_OFS;
    assign wrCc = ack_o && we_i && sel_i[0] && adr_i == sar_adc_pkg::CLOCK_CONFIG_OFS;
    // Async select as last written, kept here from the bus traffic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            asyncBit <= 1'b0;
        end else if (wrCc) begin
            asyncBit <= dat_i[sar_adc_pkg::CC_ASYNC_BIT];
        end
    end

    ack_time_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    high_zero_a: assert property (ack_o && !we_i
        && adr_i == sar_adc_pkg::RESULT_HIGH_OFS |-> dat_o[31:2] == 30'h0000_0000)
        else $error("high result not right-justified");
    no_trigger_a: assert property ($rose(converterActive) |-> $past(wrSc))
        else $error("conversion started without status write");
    chan_none_a: assert property (wrSc && dat_i[4:0] == sar_adc_pkg::CHAN_NONE
        |=> !converterActive) else $error("all-ones channel started work");
    cfg_abort_a: assert property (wrCc |=> !converterActive
        && asyncOscSlow == $past(dat_i[7])) else $error("config write handled wrongly");
    stop_abort_a: assert property (stopMode && converterActive && !asyncOscEnable
        |-> ##[0:2] !converterActive) else $error("stop did not abort");
    async_gate_a: assert property (asyncOscEnable == (converterActive && asyncBit))
        else $error("async oscillator enable wrong");
    irq_cause_a: assert property ($rose(completeIrq) |-> $past(converterActive))
        else $error("interrupt without completed conversion");
    // Main scenarios reached
    cover property ($rose(completeIrq));
    cover property (stopMode && asyncOscEnable);
    cover property (wrCc && converterActive);
endmodule

// ===== bench/sar_adc_control_test.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the analog model answers the comparator and supplies the clocks.
 */
module sar_adc_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SAMPLE_TICKS = 3;
    localparam logic [7:0] SC = sar_adc_pkg::STATUS_CONTROL_OFS;
    localparam logic [7:0] CC = sar_adc_pkg::CLOCK_CONFIG_OFS;
    localparam logic [7:0] RH = sar_adc_pkg::RESULT_HIGH_OFS;
    localparam logic [7:0] RL = sar_adc_pkg::RESULT_LOW_OFS;
    logic        clk, rstn, cyc, stb, we, ack, stopMode, cmpHigh, asyncIn, oscIn;
    logic        asyncEn, asyncSlow, sampleEn, active, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, q, rdat;
    logic [4:0]  chan;
    logic [10:0] dac;
    logic [11:0] level;
    logic [1:0]  lastHi;
    int          nErrors, cmpCount;
    logic [7:0]  cfgs [10] = '{8'h09, 8'h09, 8'h01, 8'h01, 8'h08, 8'h0C, 8'h8C, 8'h29,
                               8'h49, 8'h69};
    logic [11:0] lvs [10] = '{12'h3E9, 12'hFFF, 12'h000, 12'h3FF, 12'h2BC, 12'h7FE, 12'h200,
                              12'h14D, 12'h064, 12'h003};
    logic [7:0]  scs [10] = '{8'h03, 8'h43, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                              8'h01, 8'h01};

    sar_adc_control #(.SAMPLE_TICKS(SAMPLE_TICKS)) sar_adc_control_i (
        .clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(q), .ack_o(ack), .asyncOscIn(asyncIn), .oscOutClkIn(oscIn),
        .stopMode(stopMode), .asyncOscEnable(asyncEn), .asyncOscSlow(asyncSlow),
        .channelSelect(chan), .sampleEnable(sampleEn), .dacCode(dac), .compareHigh(cmpHigh),
        .converterActive(active), .completeIrq(irq));
    analog_side_model analog_side_model_i (
        .level(level), .sampleEnable(sampleEn), .dacCode(dac), .asyncOscEnable(asyncEn),
        .asyncOscSlow(asyncSlow), .compareHigh(cmpHigh), .asyncOscIn(asyncIn),
        .oscOutClkIn(oscIn));

    // 10 MHz bus clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wrapUp();
        $display("mismatches %0d comparisons %0d", nErrors, cmpCount);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            nErrors++;
        end
    endtask

    // One classic cycle; the request stands until the acking edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // No cycle count assumed here; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0000_0000);
        check(nm, e, rdat);
    endtask

    // Polls the flag; a status read must leave it set
    task automatic waitFlag();
        int n;
        n = 0;
        do begin
            bus(SC, 1'b0, 32'h0000_0000);
            n++;
        end while (rdat[7] !== 1'b1 && n < 400);
        if (n >= 400) nErrors++;
    endtask

    // One single conversion; expectation is the rounded, saturated level
    task automatic conv(input logic [7:0] cfg, input logic [11:0] lv, input logic [7:0] sc);
        logic [11:0] a;
        a = (lv > 12'h7FF) ? 12'h7FF : lv;
        if (!cfg[3]) a = a >> 2;
        a = (a + 12'h001) >> 1;
        if (cfg[3] && a > 12'h3FF) a = 12'h3FF;
        if (!cfg[3] && a > 12'h0FF) a = 12'h0FF;
        if (cfg[3]) lastHi = a[1:0] == 2'h0 ? a[9:8] : a[9:8];
        level <= lv;
        stopMode <= cfg[2];
        bus(CC, 1'b1, 32'(cfg));
        bus(SC, 1'b1, 32'(sc));
        waitFlag();
        rd(SC, 32'(sc) | 32'h0000_0080, "flag after status read");
        check("interrupt", 32'(sc[6]), 32'(irq));
        check("powered down", 32'h0000_0000, 32'(active));
        check("channel", 32'(sc[4:0]), 32'(chan));
        rd(RH, 32'(lastHi), "result high");
        rd(RL, 32'(a[7:0]), "result low");
        rd(SC, 32'(sc), "flag after low read");
        stopMode <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        wrapUp();
    end

    initial begin
        {cyc, stb, we, stopMode, rstn} = 5'h00;
        {adr, dat, level, lastHi} = '0;
        sel = 4'hF;
        nErrors = 0;
        cmpCount = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(SC, 32'h0000_001F, "status reset");
        rd(CC, 32'h0000_0000, "config reset");
        rd(RH, 32'h0000_0000, "high reset");
        rd(RL, 32'h0000_0000, "low reset");
        rd(8'h10, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 10; i++) begin
            conv(cfgs[i], lvs[i], scs[i]);
        end
        bus(SC, 1'b1, 32'h0000_001F);
        repeat (20) @(posedge clk);
        check("idle on no channel", 32'h0000_0000, 32'(active));
        // Config write in mid conversion: aborted, results kept
        bus(SC, 1'b1, 32'h0000_0003);
        bus(CC, 1'b1, 32'h0000_0009);
        @(posedge clk);
        check("abort by config", 32'h0000_0000, 32'(active));
        rd(RL, 32'h0000_0002, "low kept after abort");
        bus(SC, 1'b1, 32'h0000_0003);
        stopMode <= 1'b1;
        repeat (4) @(posedge clk);
        @(posedge clk);
        check("abort by stop", 32'h0000_0000, 32'(active));
        stopMode <= 1'b0;
        // Continuous mode keeps producing results
        level <= 12'h190;
        bus(SC, 1'b1, 32'h0000_0023);
        waitFlag();
        rd(RL, 32'h0000_00C8, "first continuous");
        waitFlag();
        rd(RL, 32'h0000_00C8, "second continuous");
        bus(SC, 1'b1, 32'h0000_001F);
        // High read without low read blocks the next transfer
        level <= 12'h258;
        bus(SC, 1'b1, 32'h0000_0003);
        rd(RH, 32'h0000_0000, "high before done");
        repeat (60) @(posedge clk);
        rd(SC, 32'h0000_0003, "flag held off");
        rd(RL, 32'h0000_00C8, "low kept while blocked");
        waitFlag();
        rd(RH, 32'h0000_0001, "high after block");
        rd(RL, 32'h0000_002C, "low after block");
        // Reset in mid conversion: work stops and results return to zero
        bus(SC, 1'b1, 32'h0000_0003);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        check("abort by reset", 32'h0000_0000, 32'(active));
        rd(SC, 32'h0000_001F, "status after reset");
        rd(RH, 32'h0000_0000, "high cleared by reset");
        rd(RL, 32'h0000_0000, "low cleared by reset");
        wrapUp();
    end
endmodule

bind sar_adc_control sar_adc_control_checker #(.SAMPLE_TICKS(SAMPLE_TICKS)) checker_i (
    .clk(clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .stopMode(stopMode),
    .asyncOscEnable(asyncOscEnable), .asyncOscSlow(asyncOscSlow),
    .converterActive(converterActive), .completeIrq(completeIrq));

// ===== logic/sar_adc_control.sv
/*
 * Control logic of a 10-bit successive-approximation converter: converter
 * clock select and divide, sample and bit-trial sequencing, rounding, result
 * registers, completion flag and interrupt, all behind a classic Wishbone slave.
 * Assumes an analog multiplexer and comparator outside: the comparator answers
 * compareHigh for the trial code on dacCode within one converter clock tick.
 */
// Notes on behaviour
// - One software-chosen channel is converted per conversion, from the mux output.
// - No hardware trigger; only software writes, continuous repetition or a blocked 10-bit transfer start work.
// - The alternate converter clock source is the oscillator output clock.
// - Results are right-justified, 10-bit or 8-bit by selected resolution.
// - Single and continuous modes; single mode powers down after its conversion.
// - The approximation is rounded to nearest at the selected resolution.
// - Inputs at or above high reference give full scale; at or below low give zero.
// - 8-bit result goes only to the low register; 10-bit spans high and low.
// - After the result lands, the complete flag sets and an enabled interrupt rises.
// - Async select picks the dedicated async clock, running only during conversions.
// - Low-power bit sets async clock range: 1-2 MHz clear, 0.5-1 MHz set.
// - The async clock keeps running in stop mode so conversions complete.
// - Input-clock and async select both low choose the alternate clock.
// - Input-clock select high with async select low chooses the bus clock.
// - A 2-bit field divides the chosen clock by 1, 2, 4 or 8.
// - Writing status-control starts a conversion unless the channel field is all ones or stop mode is on without async select.
// - Continuous mode restarts a conversion as soon as one completes, until aborted.
// - 10-bit mode with high byte read, low not: block transfer, flag not set, drop result.
// - Control writes, reset or stop without async clock abort; only reset clears results.
module sar_adc_control #(
    parameter int SAMPLE_TICKS = sar_adc_pkg::SAMPLE_TICKS_DEF
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    // Classic Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Clock sources and chip mode
    input  wire logic        asyncOscIn,
    input  wire logic        oscOutClkIn,
    input  wire logic        stopMode,
    output logic             asyncOscEnable,
    output logic             asyncOscSlow,
    // Analog side
    output logic      [4:0]  channelSelect,
    output logic             sampleEnable,
    output logic      [10:0] dacCode,
    input  wire logic        compareHigh,
    output logic             converterActive,
    output logic             completeIrq
);

    // Refuse sample counts the 3-bit tick counter cannot hold
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 7) begin : g_bad_sample
        $error("SAMPLE_TICKS must lie in 1..7");
    end

    typedef struct packed {
        sar_adc_pkg::conv_state_t fsm;
        logic [4:0]  chan;
        logic        irqEn;
        logic        cont;
        logic        flag;
        logic        lowPower;
        logic [1:0]  div;
        logic        mode10;
        logic        asyncSel;
        logic        inClkSel;
        logic [1:0]  resHi;
        logic [7:0]  resLo;
        logic        highRead;
        logic [10:0] sar;
        logic [10:0] mask;
        logic [10:0] trial;
        logic [2:0]  smpCnt;
        logic [2:0]  divCnt;
        logic [2:0]  aSync;
        logic [2:0]  oSync;
        logic        sampling;
        logic        ack;
        logic [31:0] rdata;
    } regs_t;

    regs_t s_q;
    regs_t s_d;

    // Divide code 0..3 gives the last count before a tick: 0, 1, 3, 7
    function automatic logic [2:0] divLast(input logic [1:0] code);
        divLast = 3'((4'h1 << code) - 4'h1);
    endfunction

    // Round an MSB-aligned approximation at a given guard bit, saturating at full scale
    function automatic logic [9:0] roundSat(input logic [10:0] v, input logic is10);
        logic [10:0] sum;
        sum = 11'h000;
        if (is10) begin
            sum = {1'b0, v[10:1]} + {10'h000, v[0]};
            roundSat = sum[10] ? 10'h3FF : sum[9:0];
        end else begin
            sum = {3'h0, v[10:3]} + {10'h000, v[2]};
            roundSat = sum[8] ? 10'h0FF : {2'h0, sum[7:0]};
        end
    endfunction

    // Start value of the bit-trial mask: top bit of the approximation
    localparam logic [10:0] MASK_TOP = 11'h400;

    logic        access;
    logic        wrStb;
    logic        rdStb;
    logic        srcEdge;
    logic        tick;
    logic        lastBit;
    logic        abort;
    logic        start;
    logic [10:0] newSar;
    logic [9:0]  rounded;
    logic [7:0]  wb8;

    always_comb begin
        s_d = s_q;

        // Bus phase: the request is acted on at the edge where ack is high
        access = cyc_i && stb_i && s_q.ack;
        wrStb  = access && we_i && sel_i[0];
        rdStb  = access && !we_i;
        wb8    = dat_i[7:0];
        s_d.ack = cyc_i && stb_i && !s_q.ack;

        // Synchronisers; the first stage feeds only the second
        s_d.aSync = {s_q.aSync[1:0], asyncOscIn};
        s_d.oSync = {s_q.oSync[1:0], oscOutClkIn};

        // Source select: async wins, else bus clock or oscillator clock
        if (s_q.asyncSel) begin
            srcEdge = s_q.aSync[1] && !s_q.aSync[2];
        end else if (s_q.inClkSel) begin
            srcEdge = 1'b1;
        end else begin
            srcEdge = s_q.oSync[1] && !s_q.oSync[2];
        end

        // Divider turns source edges into converter clock ticks
        tick = 1'b0;
        if (s_q.fsm == sar_adc_pkg::ST_IDLE) begin
            s_d.divCnt = 3'h0;
        end else if (srcEdge) begin
            if (s_q.divCnt == divLast(s_q.div)) begin
                tick = 1'b1;
                s_d.divCnt = 3'h0;
            end else begin
                s_d.divCnt = s_q.divCnt + 3'h1;
            end
        end

        // Bit trial: keep the bit when the input is at or above the trial level
        newSar  = compareHigh ? s_q.trial : s_q.sar;
        lastBit = s_q.mode10 ? s_q.mask[sar_adc_pkg::LAST_BIT_10]
                             : s_q.mask[sar_adc_pkg::LAST_BIT_8];
        rounded = roundSat(s_q.sar, s_q.mode10);

        abort = 1'b0;
        start = 1'b0;

        // Sequencer
        unique case (s_q.fsm)
            sar_adc_pkg::ST_IDLE: begin
            end
            sar_adc_pkg::ST_SAMPLE: begin
                if (tick) begin
                    if (s_q.smpCnt == 3'(SAMPLE_TICKS - 1)) begin
                        s_d.fsm   = sar_adc_pkg::ST_CONVERT;
                        s_d.sar   = 11'h000;
                        s_d.mask  = MASK_TOP;
                        s_d.trial = MASK_TOP;
                    end else begin
                        s_d.smpCnt = s_q.smpCnt + 3'h1;
                    end
                end
            end
            sar_adc_pkg::ST_CONVERT: begin
                if (tick) begin
                    s_d.sar = newSar;
                    if (lastBit) begin
                        s_d.fsm = sar_adc_pkg::ST_TRANSFER;
                    end else begin
                        s_d.mask  = s_q.mask >> 1;
                        s_d.trial = newSar | (s_q.mask >> 1);
                    end
                end
            end
            sar_adc_pkg::ST_TRANSFER: begin
                if (s_q.mode10 && s_q.highRead) begin
                    start = 1'b1;
                end else begin
                    if (s_q.mode10) begin
                        s_d.resHi = rounded[9:8];
                    end
                    s_d.resLo = rounded[7:0];
                    s_d.flag  = 1'b1;
                    start = s_q.cont;
                    if (!s_q.cont) begin
                        s_d.fsm = sar_adc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                s_d.fsm = sar_adc_pkg::ST_IDLE;
            end
        endcase

        // Read side effects: high read arms the block, low read releases and clears
        if (rdStb && adr_i == sar_adc_pkg::RESULT_HIGH_OFS) begin
            s_d.highRead = 1'b1;
        end
        if (rdStb && adr_i == sar_adc_pkg::RESULT_LOW_OFS) begin
            s_d.highRead = 1'b0;
            // A transfer landing in the same cycle keeps its flag: set wins
            if (s_q.fsm != sar_adc_pkg::ST_TRANSFER || (s_q.mode10 && s_q.highRead)) begin
                s_d.flag = 1'b0;
            end
        end

        // Register writes; each control write aborts what is running
        if (wrStb && adr_i == sar_adc_pkg::STATUS_CONTROL_OFS) begin
            s_d.irqEn = wb8[sar_adc_pkg::SC_IRQEN_BIT];
            s_d.cont  = wb8[sar_adc_pkg::SC_CONT_BIT];
            s_d.chan  = wb8[sar_adc_pkg::SC_CHAN_LSB +: sar_adc_pkg::CHAN_W];
            s_d.flag  = 1'b0;
            abort = 1'b1;
            start = (wb8[4:0] != sar_adc_pkg::CHAN_NONE);
        end
        if (wrStb && adr_i == sar_adc_pkg::CLOCK_CONFIG_OFS) begin
            s_d.lowPower = wb8[sar_adc_pkg::CC_LOWPWR_BIT];
            s_d.div      = wb8[sar_adc_pkg::CC_DIV_LSB +: 2];
            s_d.mode10   = wb8[sar_adc_pkg::CC_MODE10_BIT];
            s_d.asyncSel = wb8[sar_adc_pkg::CC_ASYNC_BIT];
            s_d.inClkSel = wb8[sar_adc_pkg::CC_INCLK_BIT];
            abort = 1'b1;
            start = 1'b0;
        end

        // Stop mode halts the other sources, so the conversion cannot finish;
        // no restart either, or it would only be cut again a cycle later
        if (stopMode && !s_q.asyncSel) begin
            abort = 1'b1;
            start = 1'b0;
        end

        // Abort leaves results alone; a start needs a real channel
        if (abort) begin
            s_d.fsm = sar_adc_pkg::ST_IDLE;
        end
        if (start && s_d.chan != sar_adc_pkg::CHAN_NONE) begin
            s_d.fsm    = sar_adc_pkg::ST_SAMPLE;
            s_d.smpCnt = 3'h0;
            s_d.divCnt = 3'h0;
        end
        s_d.sampling = (s_d.fsm == sar_adc_pkg::ST_SAMPLE);

        // Read data captured as ack rises, so it stands with ack
        s_d.rdata = 32'h0000_0000;
        if (cyc_i && stb_i && !s_q.ack && !we_i) begin
            unique case (adr_i)
                sar_adc_pkg::STATUS_CONTROL_OFS:
                    s_d.rdata = {24'h00_0000, s_q.flag, s_q.irqEn, s_q.cont, s_q.chan};
                sar_adc_pkg::CLOCK_CONFIG_OFS:
                    s_d.rdata = {24'h00_0000, s_q.lowPower, s_q.div, 1'b0,
                                 s_q.mode10, s_q.asyncSel, 1'b0, s_q.inClkSel};
                sar_adc_pkg::RESULT_HIGH_OFS:
                    s_d.rdata = {30'h0000_0000, s_q.resHi};
                sar_adc_pkg::RESULT_LOW_OFS:
                    s_d.rdata = {24'h00_0000, s_q.resLo};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Single state register; reset also clears the results
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{fsm: sar_adc_pkg::ST_IDLE, chan: sar_adc_pkg::CHAN_RESET,
                     resHi: sar_adc_pkg::RESULT_HIGH_RESET,
                     resLo: sar_adc_pkg::RESULT_LOW_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign ack_o           = s_q.ack;
    assign dat_o           = s_q.rdata;
    assign channelSelect   = s_q.chan;
    assign sampleEnable    = s_q.sampling;
    assign dacCode         = s_q.trial;
    assign converterActive = (s_q.fsm != sar_adc_pkg::ST_IDLE);
    assign asyncOscEnable  = converterActive && s_q.asyncSel;
    assign asyncOscSlow    = s_q.lowPower;
    assign completeIrq     = s_q.flag && s_q.irqEn;

endmodule

// ===== logic/sar_adc_pkg.sv
/*
 * Shared constants for the successive-approximation converter control block:
 * register offsets, field positions, reset values, state codes and tick counts.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package sar_adc_pkg;

    // Register byte offsets
    localparam logic [7:0] STATUS_CONTROL_OFS = 8'h00;
    localparam logic [7:0] CLOCK_CONFIG_OFS   = 8'h04;
    localparam logic [7:0] RESULT_HIGH_OFS    = 8'h08;
    localparam logic [7:0] RESULT_LOW_OFS     = 8'h0C;

    // Status and control register fields
    localparam int SC_FLAG_BIT   = 7;
    localparam int SC_IRQEN_BIT  = 6;
    localparam int SC_CONT_BIT   = 5;
    localparam int SC_CHAN_LSB   = 0;
    localparam int CHAN_W        = 5;
    localparam logic [4:0] CHAN_NONE = 5'h1F;

    // Clock configuration register fields
    localparam int CC_LOWPWR_BIT = 7;
    localparam int CC_DIV_LSB    = 5;
    localparam int CC_MODE10_BIT = 3;
    localparam int CC_ASYNC_BIT  = 2;
    localparam int CC_INCLK_BIT  = 0;

    // Reset values
    localparam logic [4:0] CHAN_RESET = 5'h1F;
    localparam logic [7:0] RESULT_LOW_RESET  = 8'h00;
    localparam logic [1:0] RESULT_HIGH_RESET = 2'h0;

    // Approximation width: one guard bit below the 10-bit result for rounding
    localparam int SAR_W       = 11;
    localparam int LAST_BIT_10 = 0;
    localparam int LAST_BIT_8  = 2;

    // Converter clock ticks spent sampling before the bit trials
    localparam int SAMPLE_TICKS_DEF = 4;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h1,
        ST_SAMPLE   = 4'h2,
        ST_CONVERT  = 4'h4,
        ST_TRANSFER = 4'h8
    } conv_state_t;

endpackage
